// [core/wkes_top.v]
// wakeup pin edge selection and interrupt request flags, APB slave
//
// The register addresses and register access over APB are this design's own decisions.
`timescale 1ns/1ps
`include "wkes_defs.vh"
module wkes_top
#(
   parameter NPINS = `WKES_PIN_COUNT
)
(
   // clock and reset
   input  wire        i_clk,
   input  wire        i_rst,
   // apb slave
   input  wire        i_psel,
   input  wire        i_penable,
   input  wire        i_pwrite,
   input  wire [11:0] i_paddr,
   input  wire [31:0] i_pwdata,
   output wire        o_pready,
   output wire        o_pslverr,
   output reg  [31:0] o_prdata,
   // wakeup pins, pin 5 shared with the conversion trigger
   input  wire [5:0]  i_wake_pin,
   // detection outputs
   output wire [5:0]  o_wake_edge,
   output wire        o_conv_trigger,
   output wire        o_irq
);
   // architectural state and next values
   reg  [5:0]  edge_sel_reg;
   reg  [5:0]  edge_sel_next;
   reg  [5:0]  status_reg;
   reg  [5:0]  status_next;
   reg  [5:0]  mask_reg;
   reg  [5:0]  mask_next;
   reg  [31:0] prdata_next;

   // bus decode
   wire        acc;
   wire        wr;
   wire        rd;
   wire        setup_rd;
   wire        sel_edge;
   wire        sel_status;
   wire        sel_mask;
   wire        sel_pins;
   wire        mapped;

   // per-register strobes
   wire        wr_edge;
   wire        wr_mask;
   wire        clr_status;

   // detector outputs and read path
   wire [5:0]  det;
   wire [5:0]  pending;
   reg  [31:0] rdata_next;
   reg         hit_next;

   // true when the bus offset selects the given register
   function reg_hit;
      input [11:0] a;
      input [11:0] off;
      begin
         reg_hit = (a == off);
      end
   endfunction

   // any of the four implemented registers
   function is_mapped;
      input [11:0] a;
      begin
         is_mapped = reg_hit(a, `WKES_OFF_EDGE_SEL) ||
                     reg_hit(a, `WKES_OFF_STATUS) ||
                     reg_hit(a, `WKES_OFF_MASK) ||
                     reg_hit(a, `WKES_OFF_PINS);
      end
   endfunction

   // flags left after a status read: only the reported bits are dropped
   function [5:0] clear_seen;
      input [5:0] flags;
      input [5:0] seen;
      begin
         clear_seen = flags & ~seen;
      end
   endfunction

   // transfer phases; zero wait states, so every access ends after one cycle
   assign acc        = i_psel & i_penable;
   assign wr         = acc & i_pwrite;
   assign rd         = acc & ~i_pwrite;
   assign setup_rd   = i_psel & ~i_penable & ~i_pwrite;

   // one select per register, shared by write, clear and read paths
   assign sel_edge   = reg_hit(i_paddr, `WKES_OFF_EDGE_SEL);
   assign sel_status = reg_hit(i_paddr, `WKES_OFF_STATUS);
   assign sel_mask   = reg_hit(i_paddr, `WKES_OFF_MASK);
   assign sel_pins   = reg_hit(i_paddr, `WKES_OFF_PINS);
   assign mapped     = is_mapped(i_paddr);

   // strobes; status and pin registers ignore writes
   assign wr_edge    = wr & sel_edge;
   assign wr_mask    = wr & sel_mask;
   assign clr_status = rd & sel_status;

   // handshake outputs; unmapped offsets answer with pslverr and change nothing
   assign o_pready   = 1'b1;
   assign o_pslverr  = acc & ~mapped;

   // one detector per pin, direction from its own select bit
   genvar g;
   generate
      for (g = 0; g < NPINS; g = g + 1)
      begin : g_det
         wkes_edge_det wkes_edge_det_inst
         (
            .i_clk      (i_clk),
            .i_rst      (i_rst),
            .i_pin      (i_wake_pin[g]),
            .i_rise_sel (edge_sel_reg[g]),
            .o_edge     (det[g])
         );
      end
   endgenerate

   // pulses out; trigger shares pin 5 and therefore its edge setting
   assign o_wake_edge    = det;
   assign o_conv_trigger = det[`WKES_TRIG_BIT];

   // level request while any unmasked flag is pending
   assign pending        = status_reg & mask_reg;
   assign o_irq          = |pending;

   // read mux; reserved edge bits always one, upper bits zero
   always @*
   begin
      rdata_next = 32'h0000_0000;
      hit_next   = mapped;
      if (sel_edge)
      begin
         rdata_next[`WKES_RSVD_HI:`WKES_RSVD_LO] = `WKES_RSVD_VALUE;
         rdata_next[5:0]                         = edge_sel_reg;
      end
      else if (sel_status)
         rdata_next[5:0] = status_reg;
      else if (sel_mask)
         rdata_next[5:0] = mask_reg;
      else if (sel_pins)
         rdata_next[5:0] = i_wake_pin;
   end

   // edge select next value; only the six select bits are stored
   always @*
   begin
      edge_sel_next = edge_sel_reg;
      if (wr_edge)
         edge_sel_next = i_pwdata[5:0];
   end

   // mask next value
   always @*
   begin
      mask_next = mask_reg;
      if (wr_mask)
         mask_next = i_pwdata[5:0];
   end

   // sticky flags; clearing only the captured bits keeps an edge that lands
   // between the setup and access edges, and a new edge wins over the clear
   always @*
   begin
      status_next = status_reg;
      if (clr_status)
         status_next = clear_seen(status_reg, o_prdata[5:0]);
      status_next = status_next | det;
   end

   // read data captured in the setup cycle so it stands through the access phase
   always @*
   begin
      prdata_next = o_prdata;
      if (setup_rd)
         prdata_next = hit_next ? rdata_next : 32'h0000_0000;
   end

   // edge select and mask registers, reset to falling edge everywhere
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         edge_sel_reg <= `WKES_EDGE_RESET;
         mask_reg     <= `WKES_MASK_RESET;
      end
      else
      begin
         edge_sel_reg <= edge_sel_next;
         mask_reg     <= mask_next;
      end
   end

   // request flags
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         status_reg <= `WKES_STATUS_RESET;
      else
         status_reg <= status_next;
   end

   // registered read data
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
         o_prdata <= `WKES_RDATA_RESET;
      else
         o_prdata <= prdata_next;
   end
endmodule // wkes_top

// [core/wkes_defs.vh]
// register offsets, field positions, reset values and widths of the wakeup edge selector
`ifndef WKES_DEFS_VH
`define WKES_DEFS_VH
`define WKES_OFF_EDGE_SEL   12'h000
`define WKES_OFF_STATUS     12'h004
`define WKES_OFF_MASK       12'h008
`define WKES_OFF_PINS       12'h00c
`define WKES_PIN_COUNT      6
`define WKES_RSVD_HI        7
`define WKES_RSVD_LO        6
`define WKES_TRIG_BIT       5
`define WKES_EDGE_RESET     6'h00
`define WKES_MASK_RESET     6'h00
`define WKES_STATUS_RESET   6'h00
`define WKES_RDATA_RESET    32'h0000_0000
`define WKES_RSVD_VALUE     2'h3
`endif

// [core/wkes_edge_det.v]
// one pin edge detector with selectable direction
`timescale 1ns/1ps
module wkes_edge_det
(
   // clock and reset
   input  wire i_clk,
   input  wire i_rst,
   // pin and direction
   input  wire i_pin,
   input  wire i_rise_sel,
   // detection pulse
   output wire o_edge
);
   reg prev_reg;
   reg cur_reg;

   // two successive samples of the pin
   always @(posedge i_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         prev_reg <= 1'b1;
         cur_reg  <= 1'b1;
      end
      else
      begin
         cur_reg  <= i_pin;
         prev_reg <= cur_reg;
      end
   end

   // zero selects falling, one selects rising
   assign o_edge = i_rise_sel ? (~prev_reg & cur_reg) : (prev_reg & ~cur_reg);
endmodule // wkes_edge_det

// [test/wkes_pins.sv]
// pin-side model of the wakeup lines
`timescale 1ns/1ps
module wkes_pins
(
   input  wire       i_clk,
   input  wire [5:0] i_lvl,
   output reg  [5:0] o_pin
);
   // lines idle high and move just after an edge
   initial o_pin = 6'h3f;
   always @(posedge i_clk) o_pin <= i_lvl;
endmodule // wkes_pins

// [test/wkes_props.sv]
// assertions on the wakeup edge selector ports
`timescale 1ns/1ps
module wkes_props #(parameter NPINS = 6)
(
   input wire        i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pslverr, o_irq, o_conv_trigger,
   input wire [11:0] i_paddr,
   input wire [31:0] i_pwdata, o_prdata,
   input wire [5:0]  i_wake_pin, o_wake_edge
);
   reg [5:0] sel; // shadow of the select bits
   wire      rd0 = i_psel && !i_penable && !i_pwrite && i_paddr == 12'h000;
   always @(posedge i_clk or posedge i_rst)
      if (i_rst) sel <= 6'h00;
      else if (i_psel && i_penable && i_pwrite && i_paddr == 12'h000) sel <= i_pwdata[5:0];
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   rd_rsvd_a: assert property (rd0 |=> o_prdata[7:6] == 2'h3) else $error("reserved bits");
   rd_sel_a: assert property (rd0 |=> o_prdata[5:0] == $past(sel)) else $error("select readback");
   trig_share_a: assert property (o_conv_trigger == o_wake_edge[5]) else $error("trigger");
   edge_match_a: assert property (o_wake_edge == (($past(i_wake_pin) ^ $past(i_wake_pin, 2))
      & ~($past(i_wake_pin) ^ sel))) else $error("edge pulse");
   rise_only_a: assert property (!(|(o_wake_edge & sel & ~$past(i_wake_pin)))) else $error("rise");
   fall_only_a: assert property (!(|(o_wake_edge & ~sel & $past(i_wake_pin)))) else $error("fall");
   cover property (o_conv_trigger);
   cover property (o_irq);
   cover property (o_pslverr);
endmodule // wkes_props

// [test/wkes_top_test.sv]
// self-checking bench for the wakeup edge selector
`timescale 1ns/1ps
`define CHK(n,e,g) begin checks++; if ((g) !== (e)) begin num_errors++; $display("BAD %s %h %h", n, e, g); end end
module wkes_top_test;
   reg        i_clk = 0, i_rst = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, er, tr;
   reg [11:0] i_paddr = 12'h000;
   reg [31:0] i_pwdata = 32'h0, rd;
   reg [5:0]  lvl = 6'h3f, acc;
   wire       o_pready, o_pslverr, o_conv_trigger, o_irq;
   wire [31:0] o_prdata;
   wire [5:0] i_wake_pin, o_wake_edge;
   int        num_errors = 0, checks = 0, n;
   always #4 i_clk = ~i_clk;
   wkes_pins wkes_pins_inst(.i_clk, .i_lvl(lvl), .o_pin(i_wake_pin));
   wkes_top wkes_top_inst(.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_pready,
      .o_pslverr, .o_prdata, .i_wake_pin, .o_wake_edge, .o_conv_trigger, .o_irq);
   task finish_test;
      $display("checks %0d errors %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // one transfer; held until pready is seen
   task apb(input reg w, input reg [11:0] a, input reg [31:0] d);
      @(posedge i_clk) {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, a, d};
      @(posedge i_clk) i_penable <= 1'b1;
      n = 0;
      do begin @(posedge i_clk); n++; end while (o_pready !== 1'b1 && n < 50);
      if (o_pready !== 1'b1) begin num_errors++; finish_test; end
      rd = o_prdata;
      er = o_pslverr;
      {i_psel, i_penable} <= 2'b00;
   endtask
   task t_regs;
      apb(0, 12'h000, 0); `CHK("sel", 32'hc0, rd)
      apb(1, 12'h000, 32'hffffffff); apb(0, 12'h000, 0); `CHK("sel", 32'hff, rd)
      apb(1, 12'h000, 32'h2a); apb(0, 12'h000, 0); `CHK("sel", 32'hea, rd)
      $display("reg test done");
   endtask
   // window covers pin model and sampling delays
   task t_edge(input reg [5:0] v, input reg [5:0] e, input reg t);
      acc = 6'h00; tr = 1'b0;
      @(posedge i_clk) lvl <= v;
      repeat (6) begin @(negedge i_clk); acc = acc | o_wake_edge; tr = tr | o_conv_trigger; end
      `CHK("edge", e, acc)
      `CHK("trig", t, tr)
      $display("edge test done");
   endtask
   task t_irq;
      `CHK("irq", 1'b0, o_irq)
      apb(1, 12'h008, 32'h20); repeat (2) @(posedge i_clk);
      `CHK("irq", 1'b1, o_irq)
      apb(0, 12'h004, 0); `CHK("stat", 32'h3f, rd)
      repeat (2) @(posedge i_clk); `CHK("irq", 1'b0, o_irq)
      apb(0, 12'h010, 0); `CHK("err", 1'b1, er)
      $display("irq test done");
   endtask
   // edges just before and inside a status read survive the read-clear
   task t_race;
      @(posedge i_clk) lvl <= 6'h00;
      @(posedge i_clk);
      apb(0, 12'h004, 0); `CHK("stat", 32'h0, rd)
      apb(0, 12'h004, 0); `CHK("stat", 32'h15, rd)
      @(posedge i_clk) lvl <= 6'h3f;
      apb(0, 12'h004, 0); `CHK("stat", 32'h0, rd)
      @(negedge i_clk); `CHK("irq", 1'b1, o_irq)
      apb(0, 12'h004, 0); `CHK("stat", 32'h2a, rd)
      $display("race test done");
   endtask
   // remaining registers, ignored writes and the error response
   task t_map;
      apb(0, 12'h008, 0); `CHK("mask", 32'h20, rd)
      apb(0, 12'h00c, 0); `CHK("pins", 32'h3f, rd)
      apb(1, 12'h004, 32'hffffffff); `CHK("err", 1'b0, er)
      apb(0, 12'h004, 0); `CHK("stat", 32'h0, rd)
      apb(1, 12'h010, 32'h0); `CHK("err", 1'b1, er)
      apb(0, 12'h000, 0); `CHK("sel", 32'hea, rd)
      `CHK("err", 1'b0, er)
      $display("map test done");
   endtask
   initial begin
      repeat (4) @(posedge i_clk);
      i_rst <= 1'b0;
      t_regs;
      t_edge(6'h00, 6'h15, 1'b0);
      t_edge(6'h3f, 6'h2a, 1'b1);
      t_irq;
      t_race;
      t_map;
      finish_test;
   end
endmodule // wkes_top_test
bind wkes_top wkes_props #(.NPINS(NPINS)) wkes_props_inst(.i_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
   .o_pslverr, .o_irq, .o_conv_trigger, .i_paddr, .i_pwdata, .o_prdata, .i_wake_pin, .o_wake_edge);
